// File: gpioc_pin_cell.sv
// one pin: direction, latch and peripheral override select the driver
`default_nettype none

module gpioc_pin_cell
(
    // register bits
    input wire logic dirBit,
    input wire logic latBit,
    // peripheral override
    input wire logic ovrEn,
    input wire logic ovrOe,
    input wire logic ovrVal,
    // resulting driver
    output logic drvOe,
    output logic drvVal
);

    // ****************************************
    // driver select
    // ****************************************
    always_comb
    begin
        if (ovrEn)
        begin
            drvOe = ovrOe;
            drvVal = ovrVal;
        end
        else
        begin
            drvOe = (dirBit != gpioc_pkg::DIR_INPUT);
            drvVal = latBit;
        end
    end

endmodule

`default_nettype wire

// File: gpioc_pin_model.sv
// model of the board circuitry that shares the eight port pins
`default_nettype none

module gpioc_pin_model
(
    // clock for the floating-line pattern
    input wire logic clk,
    // from the port
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    // board drivers
    input wire logic [7:0] extVal,
    input wire logic [7:0] extOe,
    // resolved levels
    output logic [7:0] pinIn
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] floatQ = 8'h5a;

    // an undriven line wanders, so a stale level cannot pass for a real one
    always @(posedge clk)
    begin
        floatQ <= ~floatQ;
    end

    // the port's driver wins where enabled, otherwise the board decides
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            pinIn[i] = pinOe[i] ? pinOut[i] : (extOe[i] ? extVal[i] : floatQ[i]);
        end
    end
endmodule

`default_nettype wire

// File: gpioc_pkg.sv
// constants shared by the eight-bit port and its pin cell
`default_nettype none

package gpioc_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_PIN_LEVELS = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_OUT_LATCH = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_DIRECTION = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_PERIPH_CTL = 4'hc;

    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int PORT_W = 8;
    localparam logic [PORT_W-1:0] DIR_RST = 8'hff;
    localparam logic [PORT_W-1:0] LAT_RST = 8'h00;
    localparam logic [PORT_W-1:0] CTL_RST = 8'h00;
    localparam logic DIR_INPUT = 1'h1;

    // ****************************************
    // peripheral control register fields
    // ****************************************
    localparam int CTL_OSC_EN = 0;
    localparam int CTL_CCP_EN = 1;
    localparam int CTL_CCP_DRIVE = 2;
    localparam int CTL_SPI_EN = 3;
    localparam int CTL_SPI_MASTER = 4;
    localparam int CTL_I2C_EN = 5;
    localparam int CTL_SER_EN = 6;
    localparam int CTL_SER_SYNC = 7;

    // ****************************************
    // bus responses
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// File: gpioc_port.sv
// eight-bit general purpose port with peripheral overrides, AXI4-Lite registers
// Functional notes
// - eight pins, each with direction, latch, level
// - direction one makes pin input, undriven
// - direction zero drives latch bit onto pin
// - latch register readable; reads return latch
// - reset leaves all pins as inputs
// - oscillator and async transmit force pin direction; other peripherals need it set first
// - direction reads return stored bits always
// - oscillator enable owns pins zero and one
// - pin zero feeds timer clock when input
// - pin three carries serial module clock
// - pin four gives serial data input
// - pin five drives serial data output
// - pin six transmit or synchronous clock
// - pin seven receive or synchronous data
// - pin seven input feeds asynchronous receive
// - pin three input feeds slave clock
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none

module gpioc_port
#(
    parameter int PortW = gpioc_pkg::PORT_W
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // write address channel
    input wire logic [gpioc_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // write data channel
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read address channel
    input wire logic [gpioc_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // read data channel
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // pins
    input wire logic [PortW-1:0] pinIn,
    output logic [PortW-1:0] pinOut,
    output logic [PortW-1:0] pinOe,
    // from peripherals
    input wire logic lowSpeedOscOut,
    input wire logic capturePinOut,
    input wire logic syncSerialClkOut,
    input wire logic syncSerialDataOut,
    input wire logic i2cClkDriveLow,
    input wire logic i2cDataDriveLow,
    input wire logic serialTxOut,
    input wire logic serialSyncClockOut,
    input wire logic serialSyncClockOe,
    input wire logic serialSyncDataOut,
    input wire logic serialSyncDataOe,
    // to peripherals
    output logic timerExtClockIn,
    output logic lowSpeedOscIn,
    output logic capturePinIn,
    output logic syncSerialClkIn,
    output logic syncSerialDataIn,
    output logic serialSyncClockIn,
    output logic serialRxIn
);

    // ****************************************
    // state
    // ****************************************
    logic [PortW-1:0] dir_q;
    logic [PortW-1:0] lat_q;
    logic [PortW-1:0] ctl_q;
    logic [PortW-1:0] level_q;
    logic [gpioc_pkg::ADDR_W-1:0] wAddr_q;
    logic [31:0] wData_q;
    logic wStrb_q;
    logic awHave_q;
    logic wHave_q;
    logic awHave_d;
    logic wHave_d;
    logic rvalid_d;
    logic awHs;
    logic wHs;
    logic arHs;
    logic commit;
    logic [PortW-1:0] ovrEn;
    logic [PortW-1:0] ovrOe;
    logic [PortW-1:0] ovrVal;
    logic [PortW-1:0] drvOe;
    logic [PortW-1:0] drvVal;
    logic oscEn;
    logic ccpDrive;
    logic spiEn;
    logic i2cEn;
    logic serAsync;
    logic serSync;

    // ****************************************
    // bus handshakes
    // ****************************************
    assign awHs = awvalid && awready;
    assign wHs = wvalid && wready;
    assign arHs = arvalid && arready;
    assign commit = awHave_q && wHave_q && !bvalid;

    always_comb
    begin
        awHave_d = commit ? 1'b0 : (awHave_q || awHs);
        wHave_d = commit ? 1'b0 : (wHave_q || wHs);
        rvalid_d = arHs || (rvalid && !rready);
    end

    // address and data are taken in either order
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            wAddr_q <= '0;
            wData_q <= '0;
            wStrb_q <= 1'b0;
        end
        else
        begin
            awHave_q <= awHave_d;
            wHave_q <= wHave_d;
            awready <= !awHave_d;
            wready <= !wHave_d;
            if (awHs)
            begin
                wAddr_q <= awaddr;
            end
            if (wHs)
            begin
                wData_q <= wdata;
                wStrb_q <= wstrb[0];
            end
        end
    end

    // write response
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bvalid <= 1'b0;
            bresp <= gpioc_pkg::RESP_OKAY;
        end
        else if (commit)
        begin
            bvalid <= 1'b1;
            unique case (wAddr_q)
                gpioc_pkg::OFS_PIN_LEVELS,
                gpioc_pkg::OFS_OUT_LATCH,
                gpioc_pkg::OFS_DIRECTION,
                gpioc_pkg::OFS_PERIPH_CTL: bresp <= gpioc_pkg::RESP_OKAY;
                default: bresp <= gpioc_pkg::RESP_SLVERR;
            endcase
        end
        else if (bready)
        begin
            bvalid <= 1'b0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dir_q <= gpioc_pkg::DIR_RST;
            lat_q <= gpioc_pkg::LAT_RST;
            ctl_q <= gpioc_pkg::CTL_RST;
        end
        else if (commit && wStrb_q)
        begin
            unique case (wAddr_q)
                // a level write lands in the latch
                gpioc_pkg::OFS_PIN_LEVELS: lat_q <= wData_q[PortW-1:0];
                gpioc_pkg::OFS_OUT_LATCH: lat_q <= wData_q[PortW-1:0];
                gpioc_pkg::OFS_DIRECTION: dir_q <= wData_q[PortW-1:0];
                gpioc_pkg::OFS_PERIPH_CTL: ctl_q <= wData_q[PortW-1:0];
                default: ;
            endcase
        end
    end

    // pin sampling
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            level_q <= '0;
        end
        else
        begin
            level_q <= pinIn;
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rvalid <= 1'b0;
            arready <= 1'b0;
            rdata <= '0;
            rresp <= gpioc_pkg::RESP_OKAY;
        end
        else
        begin
            rvalid <= rvalid_d;
            arready <= !rvalid_d;
            if (arHs)
            begin
                rresp <= gpioc_pkg::RESP_OKAY;
                rdata <= '0;
                unique case (araddr)
                    gpioc_pkg::OFS_PIN_LEVELS: rdata[PortW-1:0] <= level_q;
                    gpioc_pkg::OFS_OUT_LATCH: rdata[PortW-1:0] <= lat_q;
                    // stored bits, whatever overrides are active
                    gpioc_pkg::OFS_DIRECTION: rdata[PortW-1:0] <= dir_q;
                    gpioc_pkg::OFS_PERIPH_CTL: rdata[PortW-1:0] <= ctl_q;
                    default: rresp <= gpioc_pkg::RESP_SLVERR;
                endcase
            end
        end
    end

    // ****************************************
    // peripheral overrides
    // ****************************************
    assign oscEn = ctl_q[gpioc_pkg::CTL_OSC_EN];
    assign ccpDrive = ctl_q[gpioc_pkg::CTL_CCP_EN] && ctl_q[gpioc_pkg::CTL_CCP_DRIVE];
    assign spiEn = ctl_q[gpioc_pkg::CTL_SPI_EN];
    assign i2cEn = ctl_q[gpioc_pkg::CTL_I2C_EN] && !spiEn;
    assign serAsync = ctl_q[gpioc_pkg::CTL_SER_EN] && !ctl_q[gpioc_pkg::CTL_SER_SYNC];
    assign serSync = ctl_q[gpioc_pkg::CTL_SER_EN] && ctl_q[gpioc_pkg::CTL_SER_SYNC];

    always_comb
    begin
        ovrEn = '0;
        ovrOe = '0;
        ovrVal = '0;
        // oscillator takes both pins
        ovrEn[0] = oscEn;
        ovrOe[0] = 1'b1;
        ovrVal[0] = lowSpeedOscOut;
        ovrEn[1] = oscEn;
        // compare output needs the pin set as output
        ovrEn[2] = ccpDrive && !dir_q[2];
        ovrOe[2] = 1'b1;
        ovrVal[2] = capturePinOut;
        // module clock only once direction is input
        if (spiEn && dir_q[3])
        begin
            ovrEn[3] = 1'b1;
            ovrOe[3] = ctl_q[gpioc_pkg::CTL_SPI_MASTER];
            ovrVal[3] = syncSerialClkOut;
        end
        else if (i2cEn && dir_q[3])
        begin
            ovrEn[3] = 1'b1;
            ovrOe[3] = i2cClkDriveLow;
        end
        // open-drain data in two-wire mode
        ovrEn[4] = i2cEn && dir_q[4];
        ovrOe[4] = i2cDataDriveLow;
        ovrEn[5] = spiEn && !dir_q[5];
        ovrOe[5] = 1'b1;
        ovrVal[5] = syncSerialDataOut;
        // transmit, or bidirectional clock
        if (serAsync)
        begin
            ovrEn[6] = 1'b1;
            ovrOe[6] = 1'b1;
            ovrVal[6] = serialTxOut;
        end
        else if (serSync && dir_q[6])
        begin
            ovrEn[6] = 1'b1;
            ovrOe[6] = serialSyncClockOe;
            ovrVal[6] = serialSyncClockOut;
        end
        // bidirectional data
        ovrEn[7] = serSync && dir_q[7];
        ovrOe[7] = serialSyncDataOe;
        ovrVal[7] = serialSyncDataOut;
    end

    // ****************************************
    // pin cells
    // ****************************************
    for (genvar i = 0; i < PortW; i++)
    begin : g_pin
        gpioc_pin_cell u_cell
        (
            .dirBit(dir_q[i]),
            .latBit(lat_q[i]),
            .ovrEn(ovrEn[i]),
            .ovrOe(ovrOe[i]),
            .ovrVal(ovrVal[i]),
            .drvOe(drvOe[i]),
            .drvVal(drvVal[i])
        );
    end

    // registered pin drivers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pinOe <= '0;
            pinOut <= '0;
        end
        else
        begin
            pinOe <= drvOe;
            pinOut <= drvVal;
        end
    end

    // ****************************************
    // inputs to peripherals
    // ****************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            timerExtClockIn <= 1'b0;
            lowSpeedOscIn <= 1'b0;
            capturePinIn <= 1'b0;
            syncSerialClkIn <= 1'b0;
            syncSerialDataIn <= 1'b0;
            serialSyncClockIn <= 1'b0;
            serialRxIn <= 1'b0;
        end
        else
        begin
            timerExtClockIn <= dir_q[0] && pinIn[0];
            lowSpeedOscIn <= oscEn && pinIn[1];
            capturePinIn <= dir_q[2] && pinIn[2];
            syncSerialClkIn <= dir_q[3] && pinIn[3];
            syncSerialDataIn <= dir_q[4] && pinIn[4];
            serialSyncClockIn <= dir_q[6] && pinIn[6];
            serialRxIn <= dir_q[7] && pinIn[7];
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_reset_dir_input: assert property ($past(rst) |-> dir_q == gpioc_pkg::DIR_RST)
        else $error("direction not all input after reset");
    a_input_no_drive: assert property (!spiEn && dir_q[5] |=> !pinOe[5])
        else $error("input pin still driven");
    a_output_latch: assert property (!spiEn && !dir_q[5] |=> pinOe[5] && pinOut[5] == $past(lat_q[5]))
        else $error("output pin not showing latch");
    a_latch_readback: assert property (arHs && araddr == gpioc_pkg::OFS_OUT_LATCH
        |=> rvalid && rdata[PortW-1:0] == $past(lat_q))
        else $error("latch read wrong");
    a_dir_readback: assert property (arHs && araddr == gpioc_pkg::OFS_DIRECTION
        |=> rdata[PortW-1:0] == $past(dir_q))
        else $error("direction read wrong");
    a_osc_owns_pins: assert property (oscEn |=> pinOe[0] && !pinOe[1]
        && pinOut[0] == $past(lowSpeedOscOut))
        else $error("oscillator pins not overridden");
    a_timer_clock: assert property (dir_q[0] |=> timerExtClockIn == $past(pinIn[0]))
        else $error("timer clock input not following pin");
    a_spi_master_clk: assert property (spiEn && ctl_q[gpioc_pkg::CTL_SPI_MASTER] && dir_q[3]
        |=> pinOe[3] && pinOut[3] == $past(syncSerialClkOut))
        else $error("module clock not driven");
    a_spi_data_out: assert property (spiEn && !dir_q[5]
        |=> pinOe[5] && pinOut[5] == $past(syncSerialDataOut))
        else $error("module data not driven");
    a_serial_tx: assert property (serAsync |=> pinOe[6] && pinOut[6] == $past(serialTxOut))
        else $error("transmit data not driven");
    a_rx_input: assert property (dir_q[7] ##1 dir_q[7] |-> serialRxIn == $past(pinIn[7]))
        else $error("receive data not following pin");
    a_level_write: assert property (commit && wStrb_q && wAddr_q == gpioc_pkg::OFS_PIN_LEVELS
        |=> lat_q == $past(wData_q[PortW-1:0]) ##1 bvalid || !bready)
        else $error("level write missed latch");

    c_reg_write: cover property (commit ##1 bvalid && bready);
    c_reg_read: cover property (arHs ##1 rvalid && rready);
    c_osc_enabled: cover property (oscEn && pinOe[0]);
    c_spi_master: cover property (spiEn && pinOe[3]);

endmodule

`default_nettype wire

// File: gpioc_port_tb_top.sv
// self-checking testbench for the eight-bit port with peripheral overrides
`default_nettype none

module gpioc_port_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************
    // signals
    // ****************************************
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [gpioc_pkg::ADDR_W-1:0] awaddr, araddr;
    logic [3:0] wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [7:0] pinIn, pinOut, pinOe, extVal, extOe;
    logic [10:0] per;
    logic [6:0] toPer;
    int n_mismatch, checks_done;

    gpioc_port gpioc_port_inst (.clk(clk), .rst(rst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .lowSpeedOscOut(per[0]), .capturePinOut(per[1]), .syncSerialClkOut(per[2]),
        .syncSerialDataOut(per[3]), .i2cClkDriveLow(per[4]), .i2cDataDriveLow(per[5]),
        .serialTxOut(per[6]), .serialSyncClockOut(per[7]), .serialSyncClockOe(per[8]),
        .serialSyncDataOut(per[9]), .serialSyncDataOe(per[10]),
        .timerExtClockIn(toPer[0]), .lowSpeedOscIn(toPer[1]), .capturePinIn(toPer[2]),
        .syncSerialClkIn(toPer[3]), .syncSerialDataIn(toPer[4]),
        .serialSyncClockIn(toPer[5]), .serialRxIn(toPer[6]));

    gpioc_pin_model gpioc_pin_model_inst (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
        .extVal(extVal), .extOe(extOe), .pinIn(pinIn));

    // ****************************************
    // compare tasks and verdict
    // ****************************************
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp);
        chk_word({24'h0, got}, {24'h0, exp});
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ****************************************
    // bus tasks
    // ****************************************
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        // let the register reach the pins
        repeat (2) @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [1:0] r;
        axi_wr(a, {24'h0, d}, 4'h1, r);
        chk_word({30'h0, r}, {30'h0, gpioc_pkg::RESP_OKAY});
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk_word({30'h0, r}, {30'h0, gpioc_pkg::RESP_OKAY});
        chk_word(d, {24'h0, exp});
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        extOe <= 8'hff;
        extVal <= 8'h5a;
        chk_bits(pinOe, 8'h00);
        chk_rd(gpioc_pkg::OFS_DIRECTION, 8'hff);
        chk_rd(gpioc_pkg::OFS_OUT_LATCH, 8'h00);
        chk_rd(gpioc_pkg::OFS_PIN_LEVELS, 8'h5a);
    endtask

    task automatic t_latch_drive;
        wr(gpioc_pkg::OFS_OUT_LATCH, 8'ha5);
        extOe <= 8'h0f;
        wr(gpioc_pkg::OFS_DIRECTION, 8'h0f);
        chk_bits(pinOe, 8'hf0);
        chk_bits(pinOut & 8'hf0, 8'ha0);
        chk_rd(gpioc_pkg::OFS_PIN_LEVELS, 8'ha5 & 8'hf0 | 8'h5a & 8'h0f);
    endtask

    task automatic t_level_write;
        logic [1:0] r;
        wr(gpioc_pkg::OFS_PIN_LEVELS, 8'h3c);
        extOe <= 8'hff;
        extVal <= 8'hc3;
        wr(gpioc_pkg::OFS_DIRECTION, 8'hff);
        chk_rd(gpioc_pkg::OFS_OUT_LATCH, 8'h3c);
        chk_rd(gpioc_pkg::OFS_PIN_LEVELS, 8'hc3);
        axi_wr(gpioc_pkg::OFS_OUT_LATCH, 32'h0000_0011, 4'h0, r);
        chk_word({30'h0, r}, {30'h0, gpioc_pkg::RESP_OKAY});
        chk_rd(gpioc_pkg::OFS_OUT_LATCH, 8'h3c);
        axi_wr(4'h2, 32'h0000_0077, 4'h1, r);
        chk_word({30'h0, r}, {30'h0, gpioc_pkg::RESP_SLVERR});
        chk_rd(gpioc_pkg::OFS_OUT_LATCH, 8'h3c);
        wr(gpioc_pkg::OFS_OUT_LATCH, 8'h00);
    endtask

    task automatic t_inputs;
        logic [7:0] v;
        logic [7:0] m;
        wr(gpioc_pkg::OFS_PERIPH_CTL, 8'h08);
        for (int i = 0; i < 3; i++)
        begin
            v = (i == 1) ? 8'h66 : 8'h99;
            m = (i < 2) ? 8'hff : 8'h00;
            extVal <= v;
            extOe <= m;
            wr(gpioc_pkg::OFS_DIRECTION, m);
            chk_bits({1'b0, toPer}, {1'b0, v[7], v[6], v[4], v[3], v[2], 1'b0, v[0]} & m);
        end
    endtask

    task automatic t_osc;
        per[0] <= 1'b1;
        extOe <= 8'hfe;
        extVal <= 8'h02;
        wr(gpioc_pkg::OFS_DIRECTION, 8'hfc);
        wr(gpioc_pkg::OFS_PERIPH_CTL, 8'h01);
        chk_bits(pinOe, 8'h01);
        chk_bits(pinOut & 8'h01, 8'h01);
        chk_bits({7'h0, toPer[1]}, 8'h01);
        chk_rd(gpioc_pkg::OFS_DIRECTION, 8'hfc);
    endtask

    task automatic t_spi_master;
        per <= 11'h00e;
        extOe <= 8'hd3;
        wr(gpioc_pkg::OFS_DIRECTION, 8'hdb);
        wr(gpioc_pkg::OFS_PERIPH_CTL, 8'h1e);
        chk_bits(pinOe, 8'h2c);
        chk_bits(pinOut & 8'h2c, 8'h2c);
        chk_rd(gpioc_pkg::OFS_DIRECTION, 8'hdb);
    endtask

    task automatic t_serial;
        per <= 11'h040;
        extOe <= 8'hbf;
        wr(gpioc_pkg::OFS_DIRECTION, 8'hff);
        wr(gpioc_pkg::OFS_PERIPH_CTL, 8'h40);
        chk_bits(pinOe, 8'h40);
        chk_bits(pinOut & 8'h40, 8'h40);
        per <= 11'h590;
        extOe <= 8'h37;
        wr(gpioc_pkg::OFS_PERIPH_CTL, 8'he0);
        chk_bits(pinOe, 8'hc8);
        chk_bits(pinOut & 8'hc8, 8'h40);
    endtask

    // ****************************************
    // clock, reset, sequence and watchdog
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 4'h0;
        araddr = 4'h0;
        wstrb = 4'h0;
        wdata = 32'h0;
        per = 11'h000;
        extVal = 8'h00;
        extOe = 8'hff;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_latch_drive();
        t_level_write();
        t_inputs();
        t_osc();
        t_spi_master();
        t_serial();
        end_of_test();
    end

    initial
    begin
        #40000;
        n_mismatch++;
        end_of_test();
    end
endmodule

`default_nettype wire
